// [inc/sat_consts.svh]
// constants for the scanner front-end timing and control block
`ifndef SAT_CONSTS_SVH
`define SAT_CONSTS_SVH

`define SAT_SYNC_STAGES     2
`define SAT_RESULT_BITS     12
`define SAT_BUS_BITS        6
`define SAT_CFG_COUNT       8
`define SAT_CFG_ADDR_BITS   3
`define SAT_CFG_DATA_BITS   6
`define SAT_SHIFT_BITS      9
`define SAT_CFG_MODE_REG    3'h0
`define SAT_CFG_POWER_REG   3'h7
`define SAT_CFG_DUAL_BIT    5
`define SAT_CFG_POL_BIT     4
`define SAT_CFG_PD_BIT      0
`define SAT_OFFSET_BASE     3'h1
`define SAT_GAIN_BASE       3'h4
`define SAT_CFG_RESET       6'h00
`define SAT_PHASE_LAST      2'h3
`define SAT_WB_CTRL         6'h00
`define SAT_WB_STATUS       6'h01
`define SAT_WB_CFG_BASE     6'h10
`define SAT_CTRL_RESET      1'b1
`define SAT_MCLK_NS         100
`define SAT_MIN_SAMPLE_MCLK 4
`define SAT_MIN_LATCH_MCLK  3

`endif

// [inc/sat_pkg.sv]
// types shared by the scanner front-end timing and control block
package sat_pkg;

    typedef enum logic [1:0]
    {
        SAT_RED   = 2'b00,
        SAT_GREEN = 2'b01,
        SAT_BLUE  = 2'b10
    } sat_colour_type;

    typedef enum logic [1:0]
    {
        SAT_REF_SENSOR = 2'b00,
        SAT_REF_UPPER  = 2'b01,
        SAT_REF_LOWER  = 2'b10
    } sat_ref_type;

    typedef struct packed
    {
        logic       cyc;
        logic       stb;
        logic       we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } sat_wb_in_type;

    typedef struct packed
    {
        logic        ack;
        logic [31:0] dat;
    } sat_wb_out_type;

    typedef struct packed
    {
        logic           wbAck;
        logic [31:0]    wbDat;
        logic           ctrlEn;
        logic           prevLine;
        logic           prevStrobe;
        logic           prevSclk;
        logic           prevCommit;
        logic [8:0]     shift;
        logic [7:0][5:0] cfg;
        logic [1:0]     lineIdx;
        logic           lineSeen;
        logic [1:0]     pixCnt;
        sat_colour_type colour;
        logic [1:0]     phase;
        logic [11:0]    result;
        logic [5:0]     busData;
        logic           sigHold;
        logic           refHold;
        sat_ref_type    refSource;
    } sat_state_type;

endpackage

// [design/sat_sync.sv]
// two-stage synchroniser for a group of asynchronous inputs
`timescale 1ns/10ps
module sat_sync
    import sat_pkg::*;
#(
    parameter int WIDTH = 5
)
(
    input  wire logic             sys_clk,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;

    // first stage feeds only the second stage
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            stage1_reg <= '0;
            stage2_reg <= '0;
        end
        else
        begin
            stage1_reg <= asyncIn;
            stage2_reg <= stage1_reg;
        end
    end

    assign syncOut = stage2_reg;

endmodule

// [design/sat_afe_timing.sv]
// timing and control logic of the scanner analog front end
// Operation
// - track signal low, freeze at strobe rise
// - dual sampling holds sensor reference at fall
// - single mode holds upper/lower reference by polarity
// - clamp inputs while line high, strobe low
// - first colour selected after line-start falls
// - drive pixel bus while line-start low
// - release bus while line-start high
// - three address then six data, MSB first
// - commit rise stores data into addressed register
// - register zero bit five clear enables dual
`timescale 1ns/10ps
`include "sat_consts.svh"
module sat_afe_timing
    import sat_pkg::*;
(
    input  wire logic           sys_clk,
    input  wire logic           sys_rst,
    input  wire sat_wb_in_type  wbIn,
    output sat_wb_out_type      wbOut,
    input  wire logic           sampleStrobe,
    input  wire logic           lineStart,
    input  wire logic [5:0]     pixelBusIn,
    output logic      [5:0]     pixelBusOut,
    output logic      [5:0]     pixelBusOe,
    input  wire logic [11:0]    convResult,
    output logic                trackSignal,
    output logic                sigHoldPulse,
    output logic                refHoldPulse,
    output sat_ref_type         refSource,
    output logic                clampEnable,
    output sat_colour_type      colourSel,
    output logic      [5:0]     gainSetting,
    output logic      [5:0]     offsetSetting,
    output logic                powerDown
);

    // ------------------------------------------------------------
    // input synchronisation
    // ------------------------------------------------------------
    logic [4:0] syncBits;
    logic       strobeS;
    logic       lineS;
    logic       sclkS;
    logic       commitS;
    logic       sdiS;

    sat_sync #(.WIDTH(5)) u_sync
    (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .asyncIn ({sampleStrobe, lineStart, pixelBusIn[2:0]}),
        .syncOut (syncBits)
    );

    assign {strobeS, lineS, sclkS, commitS, sdiS} = syncBits;

    // ------------------------------------------------------------
    // colour sequencing
    // ------------------------------------------------------------
    function automatic sat_colour_type colourOf(logic [2:0] mode, logic [1:0] li, logic [1:0] pc);
        case (mode)
            3'b000:  colourOf = sat_colour_type'(li);
            3'b001:  colourOf = sat_colour_type'(pc);
            3'b011:  colourOf = SAT_RED;
            3'b100:  colourOf = SAT_GREEN;
            3'b101:  colourOf = SAT_BLUE;
            3'b110:  colourOf = li[0] ? (pc[0] ? SAT_GREEN : SAT_BLUE) : (pc[0] ? SAT_RED : SAT_GREEN);
            3'b111:  colourOf = pc[0] ? SAT_GREEN : ((li[0] ^ pc[1]) ? SAT_BLUE : SAT_RED);
            default: colourOf = SAT_RED;
        endcase
    endfunction

    sat_state_type stateReg;
    sat_state_type stateNext;

    logic [2:0] cfgMode;
    logic       dualSample;
    logic       polarity;
    logic       strobeRise;
    logic       strobeFall;
    logic       lineFall;
    logic       lineRise;
    logic       sclkRise;
    logic       commitRise;
    logic       wbReq;

    assign cfgMode    = stateReg.cfg[`SAT_CFG_MODE_REG][2:0];
    assign dualSample = !stateReg.cfg[`SAT_CFG_MODE_REG][`SAT_CFG_DUAL_BIT];
    assign polarity   = stateReg.cfg[`SAT_CFG_MODE_REG][`SAT_CFG_POL_BIT];
    assign strobeRise = strobeS && !stateReg.prevStrobe;
    assign strobeFall = !strobeS && stateReg.prevStrobe;
    assign lineFall   = !lineS && stateReg.prevLine;
    assign lineRise   = lineS && !stateReg.prevLine;
    assign sclkRise   = sclkS && !stateReg.prevSclk;
    assign commitRise = commitS && !stateReg.prevCommit;
    assign wbReq      = wbIn.cyc && wbIn.stb && !stateReg.wbAck;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic [1:0] pcNext;
        pcNext    = 2'h0;
        stateNext = stateReg;
        stateNext.prevLine   = lineS;
        stateNext.prevStrobe = strobeS;
        stateNext.prevSclk   = sclkS;
        stateNext.prevCommit = commitS;
        stateNext.sigHold    = 1'b0;
        stateNext.refHold    = 1'b0;

        // shift MSB first while commit low
        if (lineS && !commitS && sclkRise)
        begin
            stateNext.shift = {stateReg.shift[7:0], sdiS};
        end
        if (lineS && commitRise && stateReg.ctrlEn)
        begin
            stateNext.cfg[stateReg.shift[8:6]] = stateReg.shift[5:0];
            if (stateReg.shift[8:6] == `SAT_CFG_MODE_REG)
            begin
                stateNext.lineIdx  = 2'h0;
                stateNext.lineSeen = 1'b0;
            end
        end

        if (strobeRise)
        begin
            stateNext.sigHold = 1'b1;
            stateNext.result  = convResult;
            stateNext.phase   = 2'h0;
            if (!lineS)
            begin
                pcNext = (cfgMode == 3'b001 && stateReg.pixCnt == 2'h2) ? 2'h0 : stateReg.pixCnt + 2'h1;
                stateNext.pixCnt = pcNext;
                stateNext.colour = colourOf(cfgMode, stateReg.lineIdx, pcNext);
            end
        end
        else if (stateReg.phase != `SAT_PHASE_LAST)
        begin
            stateNext.phase = stateReg.phase + 2'h1;
        end

        // upper half two clocks, then lower half
        stateNext.busData = stateNext.phase[1] ? stateNext.result[5:0] : stateNext.result[11:6];

        if (strobeFall)
        begin
            stateNext.refHold = 1'b1;
            if (dualSample)
                stateNext.refSource = SAT_REF_SENSOR;
            else
                stateNext.refSource = polarity ? SAT_REF_UPPER : SAT_REF_LOWER;
        end

        if (lineFall)
        begin
            stateNext.pixCnt   = 2'h0;
            stateNext.lineSeen = 1'b1;
            stateNext.colour   = colourOf(cfgMode, stateReg.lineIdx, 2'h0);
        end
        // a line ends when line-start rises again
        if (lineRise && stateReg.lineSeen)
        begin
            stateNext.lineSeen = 1'b0;
            if ((cfgMode == 3'b000 && stateReg.lineIdx == 2'h2) || (cfgMode != 3'b000 && stateReg.lineIdx != 2'h0))
                stateNext.lineIdx = 2'h0;
            else
                stateNext.lineIdx = stateReg.lineIdx + 2'h1;
        end

        // bus slave answers one clock after the request
        stateNext.wbAck = wbReq;
        stateNext.wbDat = 32'h0000_0000;
        if (wbReq)
        begin
            if (wbIn.we && wbIn.sel[0] && wbIn.adr[7:2] == `SAT_WB_CTRL)
                stateNext.ctrlEn = wbIn.dat[0];
            if (!wbIn.we)
            begin
                if (wbIn.adr[7:2] == `SAT_WB_CTRL)
                    stateNext.wbDat[0] = stateReg.ctrlEn;
                else if (wbIn.adr[7:2] == `SAT_WB_STATUS)
                    stateNext.wbDat[5:0] = {stateReg.lineIdx, stateReg.colour, strobeS, lineS};
                else if (wbIn.adr[7:5] == 3'(`SAT_WB_CFG_BASE >> 3))
                    stateNext.wbDat[5:0] = stateReg.cfg[wbIn.adr[4:2]];
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            stateReg        <= '0;
            stateReg.ctrlEn <= `SAT_CTRL_RESET;
        end
        else
        begin
            stateReg <= stateNext;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign wbOut         = '{ack: stateReg.wbAck, dat: stateReg.wbDat};
    assign pixelBusOe    = lineS ? 6'h00 : 6'h3F;
    assign pixelBusOut   = stateReg.busData;
    assign trackSignal   = !strobeS;
    assign sigHoldPulse  = stateReg.sigHold;
    assign refHoldPulse  = stateReg.refHold;
    assign refSource     = stateReg.refSource;
    assign clampEnable   = lineS && !strobeS;
    assign colourSel     = stateReg.colour;
    assign gainSetting   = stateReg.cfg[`SAT_GAIN_BASE + 3'(stateReg.colour)];
    assign offsetSetting = stateReg.cfg[`SAT_OFFSET_BASE + 3'(stateReg.colour)];
    assign powerDown     = stateReg.cfg[`SAT_CFG_POWER_REG][`SAT_CFG_PD_BIT];

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    property p_sig_hold;
        $rose(strobeS) |=> sigHoldPulse ##1 !sigHoldPulse;
    endproperty
    a_sig_hold: assert property (p_sig_hold) else $error("signal hold not pulsed at strobe rise");

    property p_dual_ref;
        $fell(strobeS) && dualSample |=> refHoldPulse && refSource == SAT_REF_SENSOR;
    endproperty
    a_dual_ref: assert property (p_dual_ref) else $error("sensor reference not held");

    property p_single_ref;
        $fell(strobeS) && !dualSample |=> refHoldPulse && refSource == ($past(polarity) ? SAT_REF_UPPER : SAT_REF_LOWER);
    endproperty
    a_single_ref: assert property (p_single_ref) else $error("wrong internal reference held");

    property p_clamp;
        lineS && !strobeS |-> clampEnable && !trackSignal == strobeS;
    endproperty
    a_clamp: assert property (p_clamp) else $error("clamp missing");

    property p_first_colour;
        $fell(lineS) |=> colourSel == colourOf($past(cfgMode), $past(stateReg.lineIdx), 2'h0) && stateReg.pixCnt == 2'h0;
    endproperty
    a_first_colour: assert property (p_first_colour) else $error("first colour not selected");

    property p_bus_drive;
        $rose(strobeS) && !lineS ##1 !lineS[*2] |-> pixelBusOut == stateReg.result[11:6] ##1
            (lineS || $rose(strobeS) || pixelBusOut == stateReg.result[5:0]);
    endproperty
    a_bus_drive: assert property (p_bus_drive) else $error("pixel bus halves out of order");

    property p_bus_release;
        lineS |-> pixelBusOe == 6'h00;
    endproperty
    a_bus_release: assert property (p_bus_release) else $error("bus driven during line-start");

    property p_commit;
        lineS && $rose(commitS) && stateReg.ctrlEn |=> stateReg.cfg[$past(stateReg.shift[8:6])] == $past(stateReg.shift[5:0]);
    endproperty
    a_commit: assert property (p_commit) else $error("configuration write lost");

    property p_shift;
        lineS && !commitS && $rose(sclkS) |=> stateReg.shift[0] == $past(sdiS) && stateReg.shift[8:1] == $past(stateReg.shift[7:0]);
    endproperty
    a_shift: assert property (p_shift) else $error("serial bit not shifted");

    property p_wb_ack;
        wbIn.cyc && wbIn.stb && !wbOut.ack |=> wbOut.ack ##1 !wbOut.ack;
    endproperty
    a_wb_ack: assert property (p_wb_ack) else $error("bus answer not one clock");

endmodule

// [tb/sat_scan_model.sv]
// scanner controller model: strobe, line start, serial config pins and converter data
`timescale 1ns/10ps
module sat_scan_model
    import sat_pkg::*;
(
    input  wire logic        sys_clk,
    output logic             sampleStrobe,
    output logic             lineStart,
    output logic [5:0]       busDrive,
    output logic [11:0]      convResult
);
    logic [2:0] cfgPins;
    logic [2:0] idleNoise = 3'h5;

    initial
    begin
        sampleStrobe = 1'b0;
        lineStart = 1'b1;
        cfgPins = 3'h0;
        convResult = 12'h000;
    end

    // released pins toggle every cycle so a stale level is never mistaken for data
    always @(posedge sys_clk)
        idleNoise <= ~idleNoise;
    assign busDrive = lineStart ? {idleNoise, cfgPins} : {idleNoise, idleNoise};

    task automatic clks(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic strobe(input logic [11:0] r);
        convResult <= r;
        sampleStrobe <= 1'b1;
        clks(4);
        sampleStrobe <= 1'b0;
        clks(4);
    endtask

    task automatic line(input logic v);
        lineStart <= v;
        clks(5);
    endtask

    task automatic cfg_write(input logic [8:0] w);
        for (int i = 8; i >= 0; i--)
        begin
            cfgPins <= {2'b00, w[i]};
            clks(4);
            cfgPins[2] <= 1'b1;
            clks(4);
        end
        cfgPins <= 3'h2;
        clks(4);
        cfgPins <= 3'h0;
        clks(4);
    endtask

    task automatic end_cfg;
        repeat (3) strobe(12'h000);
        line(1'b0);
    endtask
endmodule

// [tb/sat_afe_timing_bench.sv]
// self-checking bench for the scanner front-end timing and control block
`timescale 1ns/10ps
module sat_afe_timing_bench
    import sat_pkg::*;
;
    localparam logic [15:0] FIRST_COL = 16'h1900;
    localparam logic [15:0] NEXT_COL  = 16'h4904;
    logic           sys_clk;
    logic           sys_rst;
    sat_wb_in_type  wbIn;
    sat_wb_out_type wbOut;
    logic           sampleStrobe;
    logic           lineStart;
    logic [5:0]     busDrive;
    logic [5:0]     busWire;
    logic [5:0]     pixelBusOut;
    logic [5:0]     pixelBusOe;
    logic [11:0]    convResult;
    logic           trackSignal;
    logic           sigHoldPulse;
    logic           refHoldPulse;
    sat_ref_type    refSource;
    logic           clampEnable;
    sat_colour_type colourSel;
    logic [5:0]     gainSetting;
    logic [5:0]     offsetSetting;
    logic           powerDown;
    int             errors;
    int             comparisons;
    int             lowAt;
    int             refCount;
    logic [11:0]    pix;
    logic [11:0]    pixQ [$];
    logic [5:0]     cfgModel [8];
    logic           ctrlModel;
    logic [5:0]     d;
    sat_ref_type    refNeg;
    sat_colour_type col;

    assign busWire = (pixelBusOe & pixelBusOut) | (~pixelBusOe & busDrive);

    sat_afe_timing u_sat_afe_timing
    (
        .sys_clk       (sys_clk),
        .sys_rst       (sys_rst),
        .wbIn          (wbIn),
        .wbOut         (wbOut),
        .sampleStrobe  (sampleStrobe),
        .lineStart     (lineStart),
        .pixelBusIn    (busWire),
        .pixelBusOut   (pixelBusOut),
        .pixelBusOe    (pixelBusOe),
        .convResult    (convResult),
        .trackSignal   (trackSignal),
        .sigHoldPulse  (sigHoldPulse),
        .refHoldPulse  (refHoldPulse),
        .refSource     (refSource),
        .clampEnable   (clampEnable),
        .colourSel     (colourSel),
        .gainSetting   (gainSetting),
        .offsetSetting (offsetSetting),
        .powerDown     (powerDown)
    );

    sat_scan_model u_sat_scan_model
    (
        .sys_clk      (sys_clk),
        .sampleStrobe (sampleStrobe),
        .lineStart    (lineStart),
        .busDrive     (busDrive),
        .convResult   (convResult)
    );

    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] dw, output logic [31:0] q);
        wbIn <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hF, dat: dw};
        // only the watchdog ends a wait for the answer
        do
        begin
            @(posedge sys_clk);
        end
        while (wbOut.ack !== 1'b1);
        chk(32'(wbOut.ack), 32'h1, "ack");
        q = wbOut.dat;
        wbIn <= '0;
        @(posedge sys_clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        chk(q, exp, what);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] dw);
        logic [31:0] q;
        wb(1'b1, a, dw, q);
    endtask

    task automatic cfg(input logic [2:0] a, input logic [5:0] dv);
        u_sat_scan_model.cfg_write({a, dv});
        if (ctrlModel)
            cfgModel[a] = dv;
    endtask

    task automatic pixel(input logic [11:0] r);
        pixQ.push_back(r);
        u_sat_scan_model.strobe(r);
    endtask

    // ----------------------------------------
    // pixel bus monitor: upper half first
    // ----------------------------------------
    always @(posedge sys_clk)
    begin
        if (lowAt == 1)
            chk(32'(pixelBusOut), 32'(pix[5:0]), "pixel lower");
        if (lowAt > 0)
            lowAt--;
        if (refHoldPulse === 1'b1)
            refCount++;
        if (sigHoldPulse === 1'b1 && pixQ.size() > 0)
        begin
            pix = pixQ.pop_front();
            chk(32'(pixelBusOut), 32'(pix[11:6]), "pixel upper");
            chk(32'(pixelBusOe), 32'h3F, "bus driven");
            lowAt = 2;
        end
    end

    task automatic wrap_up;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // a full run needs about 2000 clocks
    initial
    begin
        #1000000;
        errors++;
        $display("BAD %0t watchdog expired", $time);
        wrap_up();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        sys_rst = 1'b1;
        wbIn = '0;
        errors = 0;
        comparisons = 0;
        lowAt = 0;
        refCount = 0;
        ctrlModel = 1'b1;
        foreach (cfgModel[i])
            cfgModel[i] = 6'h00;
        void'($urandom(32'h2ebf6957));
        repeat (12) @(posedge sys_clk);
        sys_rst <= 1'b0;
        // the pin synchronisers need two clocks to show line-start high
        repeat (3) @(posedge sys_clk);
        chk(32'(pixelBusOe), 32'h0, "bus released");
        rd(8'h00, 32'h1, "ctrl reset");
        rd(8'h04, 32'h1, "status idle");
        rd(8'h44, 32'h0, "cfg reset");
        rd(8'hFC, 32'h0, "unmapped");
        wr(8'hFC, 32'hFFFFFFFF);
        wr(8'h00, 32'h0);
        ctrlModel = 1'b0;
        cfg(3'h1, 6'h2A);
        rd(8'h44, 32'h0, "commit ignored");
        wr(8'h00, 32'h1);
        ctrlModel = 1'b1;
        $display("test registers done");
        for (int n = 0; n < 8; n++)
        begin
            d = 6'($urandom);
            if (n == 7)
                d[0] = 1'b1;
            cfg(3'(n), d);
            rd(8'h40 + 8'(4 * n), 32'(cfgModel[n]), "cfg readback");
        end
        chk(32'(powerDown), 32'(cfgModel[7][0]), "power down");
        cfg(3'h7, 6'h00);
        $display("test serial writes done");
        for (int m = 0; m < 8; m++)
        begin
            cfg(3'h0, {m[0], m[1], 1'b0, m[2:0]});
            chk(32'(clampEnable), 32'h1, "clamp");
            chk(32'(trackSignal), 32'h1, "tracking");
            refCount = 0;
            u_sat_scan_model.end_cfg();
            chk(32'(clampEnable), 32'h0, "clamp off");
            chk(32'(refCount), 32'h3, "reference holds");
            if (m[0] == 1'b0)
                chk(32'(refSource), 32'(SAT_REF_SENSOR), "dual ref");
            else
            begin
                if (m == 1)
                    refNeg = refSource;
                chk(32'(refNeg == SAT_REF_SENSOR), 32'h0, "single ref");
                chk(32'(refSource), 32'(m[1] ? (refNeg ^ 2'h3) : refNeg), "polarity ref");
            end
            col = sat_colour_type'(FIRST_COL[2 * m +: 2]);
            chk(32'(colourSel), 32'(col), "first colour");
            chk(32'(gainSetting), 32'(cfgModel[4 + col]), "gain");
            chk(32'(offsetSetting), 32'(cfgModel[1 + col]), "offset");
            pixel(12'($urandom));
            chk(32'(colourSel), 32'(NEXT_COL[2 * m +: 2]), "next colour");
            pixel(12'($urandom));
            pixel(12'hFFF);
            u_sat_scan_model.line(1'b1);
            chk(32'(pixelBusOe), 32'h0, "released");
        end
        chk(32'(pixQ.size()), 32'h0, "pixels unchecked");
        $display("test lines done");
        wrap_up();
    end
endmodule
